// >>> core/sbi_top.sv
// Implementation choices: the address map and register access over APB.
`include "sbi_consts.svh"

// Contract
// - empty rx buffer read replays one frame and sets rx empty bit 1.
// - rx slip bit 0 sets on either rx replay or rx frame drop.
// - full rx buffer write drops one frame and counts as rx slip.
// - slip status bits stay set until software reads them or writes a one to them; either clears.
// - tx buffer replays a frame on empty read, drops one on full write.
// - enable bit 7 gates tx full interrupt; full write sets status bit.
// - enable bit 6 gates tx empty interrupt raised by empty read.
// - enable bit 5 gates tx slip interrupt on replay or drop.
// - a zero enable suppresses its interrupt; all bits reset to zero.
// - rx full bit 2 sets when a full rx write drops a frame.
// - tx full, empty, slip status at bits 7, 6, 5, clear on read.
// - rx full, empty, slip enables sit at bits 2, 1, 0.
module sbi_top
  import sbi_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic rx_sb_rd,
  input wire logic rx_sb_wr,
  input wire logic rx_sb_empty,
  input wire logic rx_sb_full,
  input wire logic tx_sb_rd,
  input wire logic tx_sb_wr,
  input wire logic tx_sb_empty,
  input wire logic tx_sb_full,
  output logic rx_replay,
  output logic rx_drop,
  output logic tx_replay,
  output logic tx_drop
);

  // read on empty repeats a frame, write on full deletes one
  function automatic sbi_evt_t sbi_slip_evt(
    input logic rd,
    input logic wr,
    input logic empty,
    input logic full
  );
    logic rep;
    logic del;
    rep = rd & empty;
    del = wr & full;
    return {del, rep, rep | del};
  endfunction

  sbi_reg_t status_ff;
  sbi_reg_t enable_ff;
  logic irq_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic rx_replay_ff;
  logic rx_drop_ff;
  logic tx_replay_ff;
  logic tx_drop_ff;

  sbi_evt_t rx_evt;
  sbi_evt_t tx_evt;
  sbi_reg_t evt_vec;
  sbi_reg_t clr_vec;
  sbi_reg_t wr_val;
  sbi_reg_t rd_val;
  sbi_reg_t nxt_status;
  sbi_reg_t nxt_enable;
  logic nxt_irq;
  logic [31:0] nxt_prdata;
  logic nxt_pready;
  logic nxt_pslverr;

  logic setup;
  logic access;
  logic hit_status;
  logic hit_enable;
  logic addr_ok;
  logic rd_status;
  logic wr_status;
  logic wr_enable;

  // event detection
  assign rx_evt = sbi_slip_evt(rx_sb_rd, rx_sb_wr, rx_sb_empty, rx_sb_full);
  assign tx_evt = sbi_slip_evt(tx_sb_rd, tx_sb_wr, tx_sb_empty, tx_sb_full);

  // place events at their status positions
  assign evt_vec = {tx_evt, 2'b00, rx_evt};

  // bus decode
  assign setup = psel & ~penable;
  assign access = psel & penable & pready_ff;
  assign hit_status = paddr == ADDR_W'(`SBI_OFS_STATUS);
  assign hit_enable = paddr == ADDR_W'(`SBI_OFS_ENABLE);
  assign addr_ok = hit_status | hit_enable;
  assign rd_status = access & ~pwrite & hit_status;
  assign wr_status = access & pwrite & hit_status;
  assign wr_enable = access & pwrite & hit_enable;

  // a read clears only what it returned; a one written also clears
  assign clr_vec = (rd_status ? prdata_ff[7:0] : 8'h00)
                 | (wr_status ? pwdata[7:0] : 8'h00);

  // set wins over clear
  assign nxt_status = ((status_ff & ~clr_vec) | evt_vec) & `SBI_LIVE_MASK;

  assign wr_val = pwdata[7:0] & `SBI_LIVE_MASK;
  assign nxt_enable = wr_enable ? wr_val : enable_ff;

  assign nxt_irq = |(nxt_status & nxt_enable);

  // read data is captured in the setup cycle
  assign rd_val = hit_status ? status_ff : (hit_enable ? enable_ff : 8'h00);
  assign nxt_prdata = (setup & ~pwrite) ? {24'h000000, rd_val} : prdata_ff;
  assign nxt_pready = setup;
  assign nxt_pslverr = setup & ~addr_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_ff <= `SBI_STATUS_RST;
      enable_ff <= `SBI_ENABLE_RST;
      irq_ff <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      enable_ff <= nxt_enable;
      irq_ff <= nxt_irq;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h00000000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // frame replay and drop commands to the slip buffer datapath
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_replay_ff <= 1'b0;
      rx_drop_ff <= 1'b0;
      tx_replay_ff <= 1'b0;
      tx_drop_ff <= 1'b0;
    end else begin
      rx_replay_ff <= rx_evt[1];
      rx_drop_ff <= rx_evt[2];
      tx_replay_ff <= tx_evt[1];
      tx_drop_ff <= tx_evt[2];
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq = irq_ff;
  assign rx_replay = rx_replay_ff;
  assign rx_drop = rx_drop_ff;
  assign tx_replay = tx_replay_ff;
  assign tx_drop = tx_drop_ff;

  a_rx_empty_replay: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rx_sb_rd && rx_sb_empty) |=>
      (rx_replay_ff && status_ff[`SBI_BIT_RX_EMPTY])
  ) else $error("rx empty read did not replay or set status");

  a_rx_slip_any: assert property (
    @(posedge pclk) disable iff (!presetn)
    ((rx_sb_rd && rx_sb_empty) || (rx_sb_wr && rx_sb_full)) |=>
      status_ff[`SBI_BIT_RX_SLIP]
  ) else $error("rx slip status not set");

  a_rx_full_drop: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rx_sb_wr && rx_sb_full) |=>
      (rx_drop_ff && status_ff[`SBI_BIT_RX_SLIP])
  ) else $error("rx full write did not drop a frame");

  a_rx_full_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rx_sb_wr && rx_sb_full) |=> status_ff[`SBI_BIT_RX_FULL]
  ) else $error("rx full status not set");

  a_sticky_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!rd_status && !wr_status) |=>
      ((status_ff & $past(status_ff)) == $past(status_ff))
  ) else $error("status bit dropped without a read");

  a_read_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rd_status && (evt_vec == 8'h00)) |=>
      ((status_ff & $past(clr_vec)) == 8'h00)
  ) else $error("status read did not clear reported bits");

  a_tx_replay_drop: assert property (
    @(posedge pclk) disable iff (!presetn)
    (tx_sb_rd && tx_sb_empty && tx_sb_wr && tx_sb_full) |=>
      (tx_replay_ff && tx_drop_ff && status_ff[`SBI_BIT_TX_SLIP])
  ) else $error("tx replay or drop missing");

  a_tx_full_irq: assert property (
    @(posedge pclk) disable iff (!presetn)
    (tx_sb_wr && tx_sb_full && enable_ff[`SBI_BIT_TX_FULL] && !wr_enable) |=>
      (irq_ff && status_ff[`SBI_BIT_TX_FULL])
  ) else $error("tx full interrupt not raised");

  a_tx_empty_irq: assert property (
    @(posedge pclk) disable iff (!presetn)
    (tx_sb_rd && tx_sb_empty && enable_ff[`SBI_BIT_TX_EMPTY] && !wr_enable) |=>
      (irq_ff && status_ff[`SBI_BIT_TX_EMPTY])
  ) else $error("tx empty interrupt not raised");

  a_tx_slip_irq: assert property (
    @(posedge pclk) disable iff (!presetn)
    (((tx_sb_rd && tx_sb_empty) || (tx_sb_wr && tx_sb_full))
      && enable_ff[`SBI_BIT_TX_SLIP] && !wr_enable) |=>
      (irq_ff && status_ff[`SBI_BIT_TX_SLIP])
  ) else $error("tx slip interrupt not raised");

  a_masked_quiet: assert property (
    @(posedge pclk) disable iff (!presetn)
    ((status_ff & enable_ff) == 8'h00) |-> !irq_ff
  ) else $error("interrupt high with nothing enabled");

  a_irq_level: assert property (
    @(posedge pclk) disable iff (!presetn)
    ((status_ff & enable_ff) != 8'h00) |-> irq_ff
  ) else $error("interrupt low with an enabled event pending");

  a_enable_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_enable |=> (enable_ff == $past(wr_val))
  ) else $error("enable register did not take the write");

  a_reserved_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    ((status_ff & ~`SBI_LIVE_MASK) == 8'h00) && ((enable_ff & ~`SBI_LIVE_MASK) == 8'h00)
  ) else $error("reserved bits not zero");

  a_apb_answer: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready_ff ##1 !pready_ff
  ) else $error("pready not one cycle after setup");

  a_tx_full_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    (tx_sb_wr && tx_sb_full) |=>
      (tx_drop_ff && status_ff[`SBI_BIT_TX_FULL] && status_ff[`SBI_BIT_TX_SLIP])
  ) else $error("tx full write did not drop a frame or set status");

  a_tx_empty_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    (tx_sb_rd && tx_sb_empty) |=>
      (tx_replay_ff && status_ff[`SBI_BIT_TX_EMPTY] && status_ff[`SBI_BIT_TX_SLIP])
  ) else $error("tx empty read did not replay or set status");

  a_slip_cause: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(status_ff[`SBI_BIT_RX_SLIP]) |->
      (status_ff[`SBI_BIT_RX_EMPTY] || status_ff[`SBI_BIT_RX_FULL])
  ) else $error("rx slip set without empty or full");

  a_replay_cause: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rx_replay_ff || tx_replay_ff) |->
      ($past(rx_sb_rd && rx_sb_empty) == rx_replay_ff)
      && ($past(tx_sb_rd && tx_sb_empty) == tx_replay_ff)
  ) else $error("frame replay without an empty read");

  a_drop_cause: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rx_drop_ff || tx_drop_ff) |->
      ($past(rx_sb_wr && rx_sb_full) == rx_drop_ff)
      && ($past(tx_sb_wr && tx_sb_full) == tx_drop_ff)
  ) else $error("frame drop without a full write");

  a_irq_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rd_status && (evt_vec == 8'h00) && (((status_ff & ~clr_vec) & enable_ff) == 8'h00))
      |=> !irq_ff
  ) else $error("interrupt stayed high after the clearing read");

  a_masked_event: assert property (
    @(posedge pclk) disable iff (!presetn)
    ((evt_vec != 8'h00) && (((status_ff | evt_vec) & enable_ff) == 8'h00) && !wr_enable)
      |=> !irq_ff
  ) else $error("masked slip event raised the interrupt");

  a_unmapped_err: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !addr_ok) |=> (pready_ff && pslverr_ff)
  ) else $error("unmapped address not refused");

endmodule

// >>> core/sbi_consts.svh
`ifndef SBI_CONSTS_SVH
`define SBI_CONSTS_SVH

// register byte offsets
`define SBI_OFS_STATUS 12'h000
`define SBI_OFS_ENABLE 12'h004

// field positions, shared by status and enable
`define SBI_BIT_RX_SLIP 0
`define SBI_BIT_RX_EMPTY 1
`define SBI_BIT_RX_FULL 2
`define SBI_BIT_TX_SLIP 5
`define SBI_BIT_TX_EMPTY 6
`define SBI_BIT_TX_FULL 7

// reset values and implemented bits
`define SBI_STATUS_RST 8'h00
`define SBI_ENABLE_RST 8'h00
`define SBI_LIVE_MASK 8'hE7

`endif

// >>> core/sbi_pkg.sv
package sbi_pkg;

  // one 8-bit register image, status or enable
  typedef logic [7:0] sbi_reg_t;

  // events of one slip buffer: {full, empty, slip}
  typedef logic [2:0] sbi_evt_t;

endpackage

// >>> testbench/sbi_top_tb.sv
`include "sbi_consts.svh"
module sbi_top_tb
  import sbi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  // strobes {tx_wr, tx_rd, rx_wr, rx_rd} and levels {tx_full, tx_empty, rx_full, rx_empty}
  logic [3:0] ev, lv;
  logic rx_replay, rx_drop, tx_replay, tx_drop;
  int failures, n_tests, cyc;
  sbi_reg_t m_st, m_en;

  sbi_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .rx_sb_rd(ev[0]), .rx_sb_wr(ev[1]),
    .rx_sb_empty(lv[0]), .rx_sb_full(lv[1]), .tx_sb_rd(ev[2]), .tx_sb_wr(ev[3]),
    .tx_sb_empty(lv[2]), .tx_sb_full(lv[3]), .rx_replay(rx_replay), .rx_drop(rx_drop),
    .tx_replay(tx_replay), .tx_drop(tx_drop));

  task automatic report_and_stop();
    $display("failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one apb transfer, model updated at the completing edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    logic [31:0] exp;
    logic bad;
    bad = !(a == `SBI_OFS_STATUS || a == `SBI_OFS_ENABLE);
    exp = (a == `SBI_OFS_STATUS) ? 32'(m_st) : (a == `SBI_OFS_ENABLE) ? 32'(m_en) : 32'h0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // request held until pready is seen high at a rising edge; only the timeout ends a hang
    do @(posedge pclk); while (pready !== 1'b1);
    chk(32'(pslverr), 32'(bad), "slverr");
    if (!wr) chk(prdata, exp, "rdata");
    psel <= 1'b0;
    penable <= 1'b0;
    if (!bad && wr && a == `SBI_OFS_ENABLE) m_en = d[7:0] & `SBI_LIVE_MASK;
    if (!bad && wr && a == `SBI_OFS_STATUS) m_st = m_st & ~d[7:0];
    if (!bad && !wr && a == `SBI_OFS_STATUS) m_st = 8'h00;
    @(posedge pclk);
    chk(32'(irq), 32'(|(m_st & m_en)), "irq after bus");
  endtask

  // random buffer traffic, one strobe cycle then one quiet cycle
  task automatic events(input int n);
    logic [7:0] r;
    logic [3:0] h;
    repeat (n) begin
      r = 8'($urandom);
      ev <= r[3:0];
      lv <= r[7:4];
      h = r[3:0] & r[7:4];
      @(posedge pclk);
      ev <= 4'h0;
      if (h[0]) m_st = m_st | 8'h03;
      if (h[1]) m_st = m_st | 8'h05;
      if (h[2]) m_st = m_st | 8'h60;
      if (h[3]) m_st = m_st | 8'hA0;
      @(negedge pclk);
      chk({28'h0, rx_replay, rx_drop, tx_replay, tx_drop},
        {28'h0, h[0], h[1], h[2], h[3]}, "replay/drop");
      chk(32'(irq), 32'(|(m_st & m_en)), "irq on event");
      @(posedge pclk);
    end
  endtask

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      report_and_stop();
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ev = 4'h0;
    lv = 4'h0;
    failures = 0;
    n_tests = 0;
    cyc = 0;
    m_st = `SBI_STATUS_RST;
    m_en = `SBI_ENABLE_RST;
    void'($urandom(63660));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `SBI_OFS_STATUS, 32'h0);
    apb(1'b0, `SBI_OFS_ENABLE, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    apb(1'b1, `SBI_OFS_ENABLE, 32'hFFFF_FFFF);
    apb(1'b1, 12'h00C, 32'h0);
    apb(1'b0, `SBI_OFS_ENABLE, 32'h0);
    for (int k = 0; k < 40; k++) begin
      apb(1'b1, `SBI_OFS_ENABLE, $urandom);
      events(12);
      if (k % 3 == 0) apb(1'b1, `SBI_OFS_STATUS, $urandom);
      apb(1'b0, `SBI_OFS_STATUS, 32'h0);
      if (k % 4 == 0) apb(1'b0, `SBI_OFS_STATUS, 32'h0);
    end
    report_and_stop();
  end
endmodule
